// ### qrd_pkg.sv
// constants, encodings and states of the quad i/o read path
package qrd_pkg;
	// opcodes handled by this block
	localparam logic [7:0] OP_FULL_QUAD = 8'heb;
	localparam logic [7:0] OP_WORD_QUAD = 8'he7;
	localparam logic [7:0] OP_CONT_RESET = 8'hff;
	// phase lengths in serial clocks
	localparam logic [3:0] OPCODE_CLOCKS = 4'h8;
	localparam logic [3:0] ADDR_CLOCKS = 4'h6;
	localparam logic [3:0] MODE_CLOCKS = 4'h2;
	localparam logic [3:0] DUMMY_FULL = 4'h4;
	localparam logic [3:0] DUMMY_WORD = 4'h2;
	// continuous read select value that keeps the opcode skipped
	localparam logic [1:0] CONT_SEL_KEEP = 2'h2;
	localparam int CONT_SEL_LSB = 4;
	localparam logic [7:0] CONT_BITS_RESET = 8'h00;
	// wrap setting {length field, disable bit}; disable bit at power-on
	localparam int WRAP_FIELD_LSB = 4;
	localparam logic [2:0] WRAP_RESET = 3'h1;
	localparam logic [7:0] WRAP_MIN_BYTES = 8'h08;
	// synchroniser bundle {csN, sclk, io[3:0]} at rest
	localparam logic [5:0] SYNC_RESET = 6'h20;
	localparam logic [3:0] NIBBLE_ONES = 4'hf;
	localparam int SPI_ADDR_W = 24;
	typedef enum logic [5:0] {
		QRD_IDLE = 6'h01,
		QRD_OPCODE = 6'h02,
		QRD_ADDR = 6'h04,
		QRD_MODE = 6'h08,
		QRD_DUMMY = 6'h10,
		QRD_DATA = 6'h20
	} qrd_state_e;
endpackage

// ### qrd_flash_array.sv
// byte memory of the flash array with registered read data
`timescale 1ns/1ps
module qrd_flash_array #(
	parameter int AW = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// backdoor load port
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [7:0] wrData,
	// read port
	input wire logic [AW-1:0] rdAddr,
	output logic [7:0] rdData
);
	logic [7:0] mem [0:(1<<AW)-1];
	logic [7:0] next_rdData;

	always_comb begin
		next_rdData = mem[rdAddr];
	end

	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdData <= 8'h00;
		end else begin
			rdData <= next_rdData;
		end
	end
endmodule // qrd_flash_array

// ### qrd_quad_read.sv
// quad i/o read engine with continuous read mode and burst wrap
`timescale 1ns/1ps
// Function
// - full quad read: address and data on four lines, four dummy clocks.
// - full quad read opcode accepted only while quad i/o enable is set; skipped-opcode frames read regardless of it.
// - eight mode bits follow address; bits 5..4 steer, the rest used only by the all-ones exit.
// - select bits 10 make the next frame skip the opcode.
// - any other select value restores normal opcode decoding.
// - continuous read reset opcode clears the stored mode bits.
// - stored wrap setting decides wrap or linear addressing for reads.
// - wrap enabled: output wraps inside the aligned section until deselect.
// - three wrap bits held: one disable bit, two-bit length field.
// - word quad read: host gives even address, two dummy clocks.
// - word quad read opcode accepted only while quad i/o enable is set; skipped-opcode frames read regardless of it.
// - word quad read also honours select bits 10 to skip opcode.
// - word quad read uses the wrap setting like the full read.
// - wrap disable bit is one after reset, reads linear.
// - four clocks of all ones (last two address clocks, both mode clocks) leave continuous read mode.
// - top wrap bit and low four wrap bits are ignored.
module qrd_quad_read
	import qrd_pkg::*;
#(
	parameter int MEM_AW = 12
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// serial link pins, sampled asynchronously
	input wire logic csN,
	input wire logic sclk,
	input wire logic [3:0] quadIoIn,
	output logic [3:0] quadIoOut,
	output logic [3:0] quadIoOe,
	// configuration
	input wire logic quadIoEnableBit,
	input wire logic wrapLoad,
	input wire logic [7:0] wrapSettingIn,
	// array load port
	input wire logic memWrEn,
	input wire logic [MEM_AW-1:0] memWrAddr,
	input wire logic [7:0] memWrData,
	// status
	output logic contModeActive,
	output logic [2:0] wrapSettingBits
);
	import qrd_pkg::*;

	logic [5:0] sync1, sync2, sync3, filt, filtPrev;
	logic [5:0] next_filt;
	logic csLow, sclkRise, sclkFall, csFall;
	logic [3:0] ioNow;

	qrd_state_e state, next_state;
	logic [3:0] cnt, next_cnt;
	logic [7:0] shiftReg, next_shiftReg;
	logic [SPI_ADDR_W-1:0] addr, next_addr;
	logic isWord, next_isWord;
	logic contWord, next_contWord;
	logic [7:0] contBits, next_contBits;
	logic nibbleLo, next_nibbleLo;
	logic [3:0] next_quadIoOut, next_quadIoOe;
	logic next_contModeActive;
	logic [2:0] next_wrapSettingBits;
	logic [7:0] rdData, wrapMask, byteNext;
	logic [7:0] opByte, modeByte;
	logic [SPI_ADDR_W-1:0] stepAddr;

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sync1 <= SYNC_RESET;
			sync2 <= SYNC_RESET;
			sync3 <= SYNC_RESET;
			filt <= SYNC_RESET;
			filtPrev <= SYNC_RESET;
		end else begin
			sync1 <= {csN, sclk, quadIoIn};
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= next_filt;
			filtPrev <= filt;
		end
	end

	for (genvar i = 0; i < 6; i++) begin : g_filt
		assign next_filt[i] = (sync2[i] == sync3[i]) ? sync2[i] : filt[i];
	end

	assign csLow = ~filt[5];
	assign csFall = filtPrev[5] & ~filt[5];
	assign sclkRise = csLow & filt[4] & ~filtPrev[4];
	assign sclkFall = csLow & ~filt[4] & filtPrev[4];
	assign ioNow = filt[3:0];

	qrd_flash_array #(
		.AW(MEM_AW)
	) u_array (
		.clk(ref_clk),
		.nrst(nrst),
		.wrEn(memWrEn),
		.wrAddr(memWrAddr),
		.wrData(memWrData),
		.rdAddr(addr[MEM_AW-1:0]),
		.rdData(rdData)
	);

	// wrap only inside the aligned section when disable bit is zero
	always_comb begin
		wrapMask = 8'((WRAP_MIN_BYTES << wrapSettingBits[2:1]) - 8'h01);
		byteNext = 8'(addr[7:0] + 8'h01);
		if (!wrapSettingBits[0]) begin
			stepAddr = {addr[SPI_ADDR_W-1:8],
				(addr[7:0] & ~wrapMask) | (byteNext & wrapMask)};
		end else begin
			stepAddr = SPI_ADDR_W'(addr + 1'b1);
		end
	end

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_shiftReg = shiftReg;
		next_addr = addr;
		next_isWord = isWord;
		next_contWord = contWord;
		next_contBits = contBits;
		next_nibbleLo = nibbleLo;
		next_quadIoOut = quadIoOut;
		next_quadIoOe = quadIoOe;
		next_wrapSettingBits = wrapSettingBits;
		opByte = {shiftReg[6:0], ioNow[0]};
		modeByte = {shiftReg[3:0], ioNow};
		// only bits 6..4 of the setting byte are kept
		if (wrapLoad) begin
			next_wrapSettingBits = wrapSettingIn[WRAP_FIELD_LSB +: 3];
		end
		if (!csLow) begin
			// deselect ends the frame and frees the lines at once
			next_state = QRD_IDLE;
			next_quadIoOe = 4'h0;
		end else if (csFall) begin
			next_cnt = 4'h0;
			next_nibbleLo = 1'b0;
			if (contModeActive) begin
				next_state = QRD_ADDR;
				next_isWord = contWord;
			end else begin
				next_state = QRD_OPCODE;
			end
		end else if (sclkRise) begin
			unique case (state)
				QRD_OPCODE: begin
					next_shiftReg = opByte;
					next_cnt = 4'(cnt + 4'h1);
					if (cnt == OPCODE_CLOCKS - 4'h1) begin
						next_cnt = 4'h0;
						next_state = QRD_IDLE;
						if (opByte == OP_FULL_QUAD && quadIoEnableBit) begin
							next_state = QRD_ADDR;
							next_isWord = 1'b0;
						end else if (opByte == OP_WORD_QUAD && quadIoEnableBit) begin
							next_state = QRD_ADDR;
							next_isWord = 1'b1;
						end else if (opByte == OP_CONT_RESET) begin
							next_contBits = CONT_BITS_RESET;
						end
					end
				end
				QRD_ADDR: begin
					next_addr = {addr[SPI_ADDR_W-5:0], ioNow};
					next_cnt = 4'(cnt + 4'h1);
					if (cnt == ADDR_CLOCKS - 4'h1) begin
						next_cnt = 4'h0;
						next_state = QRD_MODE;
					end
				end
				QRD_MODE: begin
					next_shiftReg = modeByte;
					next_cnt = 4'(cnt + 4'h1);
					if (cnt == MODE_CLOCKS - 4'h1) begin
						// low nibble is stored but steers only the all-ones exit check below
						next_contBits = modeByte;
						next_contWord = isWord;
						next_cnt = 4'h0;
						next_state = QRD_DUMMY;
						// four clocks of ones (last two address clocks and both mode clocks) in a skipped-opcode frame
						if (contModeActive && modeByte == OP_CONT_RESET &&
							addr[7:0] == {NIBBLE_ONES, NIBBLE_ONES}) begin
							next_contBits = CONT_BITS_RESET;
							next_state = QRD_IDLE;
						end
					end
				end
				QRD_DUMMY: begin
					next_cnt = 4'(cnt + 4'h1);
					if (cnt == (isWord ? DUMMY_WORD : DUMMY_FULL) - 4'h1) begin
						next_state = QRD_DATA;
						next_nibbleLo = 1'b0;
					end
				end
				QRD_IDLE, QRD_DATA: begin
				end
			endcase
		end else if (sclkFall && state == QRD_DATA) begin
			// host has released the lines by now
			next_quadIoOe = NIBBLE_ONES;
			next_quadIoOut = nibbleLo ? rdData[3:0] : rdData[7:4];
			next_nibbleLo = ~nibbleLo;
			if (nibbleLo) begin
				next_addr = stepAddr;
			end
		end
		next_contModeActive =
			(next_contBits[CONT_SEL_LSB +: 2] == CONT_SEL_KEEP);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= QRD_IDLE;
			cnt <= 4'h0;
			shiftReg <= 8'h00;
			addr <= '0;
			isWord <= 1'b0;
			contWord <= 1'b0;
			contBits <= CONT_BITS_RESET;
			nibbleLo <= 1'b0;
			quadIoOut <= 4'h0;
			quadIoOe <= 4'h0;
			contModeActive <= 1'b0;
			wrapSettingBits <= WRAP_RESET;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			shiftReg <= next_shiftReg;
			addr <= next_addr;
			isWord <= next_isWord;
			contWord <= next_contWord;
			contBits <= next_contBits;
			nibbleLo <= next_nibbleLo;
			quadIoOut <= next_quadIoOut;
			quadIoOe <= next_quadIoOe;
			contModeActive <= next_contModeActive;
			wrapSettingBits <= next_wrapSettingBits;
		end
	end
endmodule // qrd_quad_read

// ### qrd_quad_read_asserts.sv
// port checker of the quad read engine
`timescale 1ns/1ps
module qrd_quad_read_asserts (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// inputs
	input wire logic csN,
	input wire logic quadIoEnableBit,
	input wire logic wrapLoad,
	input wire logic [7:0] wrapSettingIn,
	// outputs
	input wire logic [3:0] quadIoOut,
	input wire logic [3:0] quadIoOe,
	input wire logic contModeActive,
	input wire logic [2:0] wrapSettingBits
);
	import qrd_pkg::*;
	logic [2:0] wIn;
	assign wIn = wrapSettingIn[6:4];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence oeOff;
		##[1:8] quadIoOe == 4'h0;
	endsequence
	sequence outHeld;
		$stable(quadIoOut) [*6];
	endsequence
	oe_same_lanes_a: assert property (quadIoOe == 4'h0 || quadIoOe == 4'hf)
		else $error("oe lanes differ");
	oe_off_deselect_a: assert property ($rose(csN) |-> oeOff)
		else $error("oe kept after deselect");
	nibble_held_a: assert property ($changed(quadIoOut) && quadIoOe[0] |=> outHeld)
		else $error("nibble not held");
	wrap_load_a: assert property (wrapLoad |=> wrapSettingBits == $past(wIn))
		else $error("wrap bits not loaded");
	wrap_hold_a: assert property (!wrapLoad |=> $stable(wrapSettingBits))
		else $error("wrap bits changed");
	reset_value_a: assert property (disable iff (1'b0) $rose(nrst) |->
		wrapSettingBits == WRAP_RESET && !contModeActive && quadIoOe == 4'h0)
		else $error("bad reset value");
	enable_gate_a: assert property ($rose(quadIoOe[0]) |-> $past(quadIoEnableBit, 40))
		else $error("read without enable");
	mode_in_frame_a: assert property ($changed(contModeActive) |-> !csN)
		else $error("mode changed outside frame");
endmodule // qrd_quad_read_asserts
bind qrd_quad_read qrd_quad_read_asserts qrd_quad_read_asserts_inst (
	.ref_clk(ref_clk), .nrst(nrst), .csN(csN),
	.quadIoEnableBit(quadIoEnableBit), .wrapLoad(wrapLoad),
	.wrapSettingIn(wrapSettingIn), .quadIoOut(quadIoOut), .quadIoOe(quadIoOe),
	.contModeActive(contModeActive), .wrapSettingBits(wrapSettingBits)
);

// ### qrd_host_model.sv
// host quad spi controller model
`timescale 1ns/1ps
module qrd_host_model (
	// link pins
	output logic csN,
	output logic sclk,
	output logic [3:0] hostIo,
	output logic hostOe,
	input wire logic [3:0] quadIoWire,
	// received bytes
	output logic rxValid,
	output logic [7:0] rxByte
);
	import qrd_pkg::*;
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		hostIo = 4'h0;
		hostOe = 1'b0;
		rxValid = 1'b0;
		rxByte = 8'h00;
	end
	task automatic tick(input logic [3:0] v);
		hostIo = v;
		#24 sclk = 1'b1;
		#24 sclk = 1'b0;
	endtask
	// slow host: samples just before the next fall, no race with output
	task automatic frame(input logic [7:0] op, input logic skip,
		input logic [23:0] a, input logic [7:0] m, input int dmy, input int n);
		csN = 1'b0;
		hostOe = 1'b1;
		#24;
		if (!skip)
			for (int i = 7; i >= 0; i--) tick({3'h0, op[i]});
		if (skip || op != OP_CONT_RESET) begin
			for (int i = 5; i >= 0; i--) tick(a[i*4+:4]);
			tick(m[7:4]);
			tick(m[3:0]);
			hostOe = 1'b0;
			repeat (dmy) tick(hostIo);
			// keeps the data clock at the same 48 ns period as the command
			for (int k = 0; k < 2 * n; k++) begin
				#24 sclk = 1'b1;
				#23 rxValid = 1'b0;
				#1 rxByte = {rxByte[3:0], quadIoWire};
				sclk = 1'b0;
				rxValid = k[0];
			end
			#1 rxValid = 1'b0;
		end
		hostOe = 1'b0;
		#48 csN = 1'b1;
		#96;
	endtask
endmodule // qrd_host_model

// ### tb_qrd_quad_read.sv
// self-checking bench of the quad read engine
`timescale 1ns/1ps
module tb_qrd_quad_read;
	import qrd_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic csN, sclk, hostOe, rxValid, contModeActive;
	logic [3:0] hostIo, quadIoIn, quadIoOut, quadIoOe;
	logic quadIoEnableBit = 1'b1;
	logic wrapLoad = 1'b0;
	logic [7:0] wrapSettingIn = 8'h00;
	logic memWrEn = 1'b0;
	logic [9:0] memWrAddr = 10'h000;
	logic [7:0] memWrData = 8'h00;
	logic [2:0] wrapSettingBits;
	logic [7:0] rxByte;
	logic [7:0] mem [1024];
	logic [7:0] expQ [$];
	logic oeSeen = 1'b0;
	logic wDis = 1'b1;
	logic [1:0] wLen = 2'h0;
	logic [23:0] a;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	always #2.5 ref_clk = ~ref_clk;
	// unowned lines show the inverse of the last value
	assign quadIoIn = quadIoOe[0] ? quadIoOut : hostOe ? hostIo : ~hostIo;
	qrd_quad_read #(.MEM_AW(10)) qrd_quad_read_inst (.ref_clk(ref_clk),
		.nrst(nrst), .csN(csN), .sclk(sclk), .quadIoIn(quadIoIn),
		.quadIoOut(quadIoOut), .quadIoOe(quadIoOe), .wrapLoad(wrapLoad),
		.quadIoEnableBit(quadIoEnableBit), .wrapSettingIn(wrapSettingIn),
		.memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData),
		.contModeActive(contModeActive), .wrapSettingBits(wrapSettingBits));
	qrd_host_model qrd_host_model_inst (.csN(csN), .sclk(sclk),
		.hostIo(hostIo), .hostOe(hostOe), .quadIoWire(quadIoIn),
		.rxValid(rxValid), .rxByte(rxByte));
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] op, input logic skip,
		input logic [23:0] ad, input logic [7:0] m, input int n);
		logic [23:0] p;
		logic [23:0] msk;
		p = ad;
		msk = wDis ? 24'hffffff : (24'h8 << wLen) - 24'h1;
		for (int i = 0; i < n; i++) begin
			expQ.push_back(mem[p[9:0]]);
			p = (p & ~msk) | ((p + 24'h1) & msk);
		end
		qrd_host_model_inst.frame(op, skip, ad, m,
			(op == OP_WORD_QUAD) ? 2 : 4, n);
	endtask
	task automatic setWrap(input logic [7:0] w);
		@(negedge ref_clk) wrapSettingIn = w;
		wrapLoad = 1'b1;
		@(negedge ref_clk) wrapLoad = 1'b0;
		wDis = w[4];
		wLen = w[6:5];
		@(negedge ref_clk) chk("wrap", {w[6:5], w[4]}, wrapSettingBits);
	endtask
	always @(posedge rxValid) chk("byte", expQ.pop_front(), rxByte);
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (quadIoOe[0] === 1'b1)
			oeSeen <= 1'b1;
		if (cyc == 60000) begin
			err_count++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(32'h03fe));
		repeat (20) @(negedge ref_clk);
		nrst = 1'b1;
		chk("rst", WRAP_RESET, wrapSettingBits);
		for (int i = 0; i < 1024; i++) begin
			@(negedge ref_clk);
			memWrEn = 1'b1;
			memWrAddr = 10'(i);
			memWrData = 8'($urandom);
			mem[i] = memWrData;
		end
		@(negedge ref_clk) memWrEn = 1'b0;
		rd(OP_FULL_QUAD, 1'b0, 24'($urandom) | 24'h3fc, 8'h00, 8);
		chk("cont", 1'b0, contModeActive);
		for (int f = 0; f < 4; f++) begin
			setWrap({1'b1, 2'(f), 1'b0, 4'hf});
			a = 24'($urandom) & 24'hfffffe;
			rd(f[0] ? OP_WORD_QUAD : OP_FULL_QUAD, 1'b0, a,
				{4'h2, 4'($urandom)}, (8 << f) + 2);
			chk("on", 1'b1, contModeActive);
			rd(f[0] ? OP_WORD_QUAD : OP_FULL_QUAD, 1'b1, a ^ 24'h10, 8'h00, 4);
			chk("off", 1'b0, contModeActive);
		end
		setWrap(8'h10);
		rd(OP_FULL_QUAD, 1'b0, 24'h0000fe, 8'h20, 3);
		qrd_host_model_inst.frame(OP_FULL_QUAD, 1'b1, 24'hffffff, 8'hff, 0, 0);
		chk("ones", 1'b0, contModeActive);
		qrd_host_model_inst.frame(OP_CONT_RESET, 1'b0, 24'h0, 8'h00, 0, 0);
		chk("reset op", 1'b0, contModeActive);
		@(negedge ref_clk) quadIoEnableBit = 1'b0;
		oeSeen = 1'b0;
		rd(OP_FULL_QUAD, 1'b0, 24'h0, 8'h00, 0);
		rd(OP_WORD_QUAD, 1'b0, 24'h0, 8'h00, 0);
		chk("refused", 1'b0, oeSeen);
		@(negedge ref_clk) quadIoEnableBit = 1'b1;
		chk("left", 0, expQ.size());
		tally_and_finish();
	end
endmodule // tb_qrd_quad_read
